// ---- core/pseq_core.sv ----
// Program sequencer: phases, counter, dummy cycles, return stack, APB regs
`timescale 1ns/1ns
`include "pseq_map.svh"
module pseq_core
(
   input wire logic ref_clk_i,          // 250 MHz system clock
   input wire logic rst_i,              // async reset, active high
   input wire logic psel,               // APB select
   input wire logic penable,            // APB access phase
   input wire logic pwrite,             // APB direction
   input wire logic [11:0] paddr,       // APB byte address
   input wire logic [31:0] pwdata,      // APB write data
   output logic [31:0] prdata,          // APB read data
   output logic pready,                 // APB ready
   output logic pslverr,                // APB error
   input wire pseq_pkg::pseq_op_t op_i, // execute-stage decode
   input wire logic op_valid_i,         // op_i valid in exec phase
   input wire logic irq_i,              // async interrupt request pin
   output logic [11:0] fetch_addr_o,    // program memory address
   output logic fetch_o,                // fetch strobe, one cycle
   output logic dummy_o,                // current cycle is a dummy
   output logic irq_ack_o,              // interrupt acknowledge pulse
   output pseq_pkg::pseq_phase_t phase_o // current phase
);
   pseq_pkg::pseq_phase_t phase;
   logic [3:0] pc_upper_bits;
   logic [7:0] pc_low_byte;
   logic [2:0] sp;
   logic [3:0] depth;
   logic dummy;
   logic irq_en;
   logic irq_pend;
   logic irq_s1;
   logic irq_s2;
   logic [11:0] pc;
   logic [11:0] stk_rdata;
   logic [2:0] top_slot;
   logic apb_wr;
   logic pc_low_wr;
   logic end_cycle;
   logic exec_ok;
   logic take_irq;
   logic stack_full;
   logic push;
   logic pop;
   logic [31:0] rd_word;
   logic addr_bad;

   // All checks run on the system clock and rest during reset
   default clocking chk_clk @(posedge ref_clk_i);
   endclocking
   default disable iff (rst_i);

   assign pc = {pc_upper_bits, pc_low_byte};
   assign top_slot = sp - 3'h1;
   assign stack_full = (depth == 4'(`PSEQ_STACK_DEPTH));
   assign end_cycle = (phase == pseq_pkg::PH_EXB);
   assign exec_ok = op_valid_i && !dummy;
   assign apb_wr = psel && penable && pwrite;
   assign pc_low_wr = apb_wr && (paddr == `PSEQ_ADDR_PC_LOW);
   // Interrupt blocked while the stack is full
   assign take_irq = end_cycle && irq_pend && irq_en && !stack_full
      && !dummy;
   assign push = end_cycle && ((exec_ok && op_i.call) || take_irq);
   assign pop = end_cycle && exec_ok && op_i.pop_pc && !take_irq;

   ////////////////////////////////////////////////////////////////////////
   // Four-phase sequencing, one instruction cycle per round
   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         phase <= pseq_pkg::PH_FETCH;
      end
      else
      begin
         case (phase)
            pseq_pkg::PH_FETCH: phase <= pseq_pkg::PH_DEC;
            pseq_pkg::PH_DEC: phase <= pseq_pkg::PH_EXA;
            pseq_pkg::PH_EXA: phase <= pseq_pkg::PH_EXB;
            pseq_pkg::PH_EXB: phase <= pseq_pkg::PH_FETCH;
            default: phase <= pseq_pkg::PH_FETCH;
         endcase
      end
   end
   assign phase_o = phase;
   // Fetch in the first phase; the word executes at the end of the same round
   assign fetch_o = (phase == pseq_pkg::PH_FETCH);
   assign fetch_addr_o = pc;

   ////////////////////////////////////////////////////////////////////////
   // Program counter: steps at the cycle end, loads on flow changes
   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         {pc_upper_bits, pc_low_byte} <= `PSEQ_RESET_VECTOR;
      end
      else if (end_cycle)
      begin
         if (take_irq)
         begin
            {pc_upper_bits, pc_low_byte} <= `PSEQ_IRQ_VECTOR;
         end
         else if (exec_ok && op_i.branch)
         begin
            {pc_upper_bits, pc_low_byte} <= op_i.target;
         end
         else if (pop)
         begin
            {pc_upper_bits, pc_low_byte} <= stk_rdata;
         end
         else if (pc_low_wr)
         begin
            pc_low_byte <= pwdata[7:0];
         end
         else if (dummy)
         begin
            // Dummy only refetches; stepping here would lose the target
            {pc_upper_bits, pc_low_byte} <= pc;
         end
         else if (exec_ok && op_i.skip)
         begin
            // Next word is dropped; the dummy fetches the one after
            {pc_upper_bits, pc_low_byte} <= pc + 12'h002;
         end
         else
         begin
            {pc_upper_bits, pc_low_byte} <= pc + 12'h001;
         end
      end
      else if (pc_low_wr)
      begin
         // Page-local jump; the upper bits are untouched
         pc_low_byte <= pwdata[7:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Dummy cycle after a flow change, taken skip or low-byte write
   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         dummy <= 1'b0;
      end
      else if (end_cycle)
      begin
         dummy <= take_irq || pc_low_wr || (exec_ok && (op_i.branch
            || op_i.pop_pc || op_i.skip));
      end
      else if (pc_low_wr)
      begin
         dummy <= 1'b1;
      end
   end
   assign dummy_o = dummy;

   ////////////////////////////////////////////////////////////////////////
   // Stack pointer and depth; the pointer wraps so the oldest is lost
   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         sp <= `PSEQ_SP_TOP;
         depth <= 4'h0;
      end
      else if (push)
      begin
         sp <= sp + 3'h1;
         if (!stack_full)
         begin
            depth <= depth + 4'h1;
         end
      end
      else if (pop && depth != 4'h0)
      begin
         sp <= sp - 3'h1;
         depth <= depth - 4'h1;
      end
   end

   // Hidden store; no bus path reaches it
   pseq_stack_mem u_stack (
      .ref_clk_i (ref_clk_i),
      .wr_i (push),
      .waddr_i (sp),
      .wdata_i (take_irq ? pc : pc + 12'h001),
      .raddr_i (top_slot),
      .rdata_o (stk_rdata)
   );

   ////////////////////////////////////////////////////////////////////////
   // Interrupt pin synchroniser and pending flag
   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         irq_s1 <= 1'b0;
         irq_s2 <= 1'b0;
      end
      else
      begin
         irq_s1 <= irq_i;
         irq_s2 <= irq_s1;
      end
   end

   // A new request wins over the acknowledge clear
   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         irq_pend <= 1'b0;
      end
      else if (irq_s2 && irq_en)
      begin
         irq_pend <= 1'b1;
      end
      else if (take_irq)
      begin
         irq_pend <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         irq_ack_o <= 1'b0;
      end
      else
      begin
         irq_ack_o <= take_irq;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // APB slave: zero wait states, unmapped addresses error
   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         irq_en <= 1'b0;
      end
      else if (apb_wr && paddr == `PSEQ_ADDR_CTRL)
      begin
         irq_en <= pwdata[`PSEQ_CTRL_IRQ_EN];
      end
   end

   assign pready = 1'b1;

   // Read word and address decode
   always_comb
   begin
      rd_word = 32'h0000_0000;
      addr_bad = 1'b0;
      case (paddr)
         `PSEQ_ADDR_PC_LOW: rd_word[7:0] = pc_low_byte;
         `PSEQ_ADDR_CTRL: rd_word[`PSEQ_CTRL_IRQ_EN] = irq_en;
         `PSEQ_ADDR_STAT:
         begin
            rd_word[`PSEQ_STAT_FULL] = stack_full;
            rd_word[`PSEQ_STAT_PEND] = irq_pend;
            rd_word[`PSEQ_STAT_DUMMY] = dummy;
         end
         default: addr_bad = 1'b1;
      endcase
   end
   assign pslverr = psel && penable && addr_bad;

   // Read data taken in the setup cycle, so status is one clock old
   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         prdata <= 32'h0000_0000;
      end
      else if (psel && !penable)
      begin
         prdata <= rd_word;
      end
      else
      begin
         prdata <= 32'h0000_0000;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks
   phase_ring_a: assert property (
      phase == pseq_pkg::PH_FETCH |=> phase == pseq_pkg::PH_DEC ##1
      phase == pseq_pkg::PH_EXA ##1 phase == pseq_pkg::PH_EXB)
      else $error("phase ring broken");
   pc_step_a: assert property (
      end_cycle && !dummy && !take_irq && !pc_low_wr && !(op_valid_i
      && (op_i.branch || op_i.pop_pc || op_i.skip)) |=>
      pc == $past(pc) + 12'h001)
      else $error("counter did not step");
   low_page_a: assert property (
      pc_low_wr && !end_cycle |=> pc_upper_bits == $past(pc_upper_bits)
      && pc_low_byte == $past(pwdata[7:0]) && dummy)
      else $error("low byte write left page");
   skip_dummy_a: assert property (
      end_cycle && exec_ok && op_i.skip |=> dummy [*4])
      else $error("skip without dummy");
   skip_step_a: assert property (
      end_cycle && exec_ok && op_i.skip && !op_i.branch && !op_i.pop_pc
      && !take_irq && !pc_low_wr |=> pc == $past(pc) + 12'h002)
      else $error("skip did not pass the next word");
   dummy_quiet_a: assert property (
      dummy && end_cycle && !take_irq |-> !push && !pop)
      else $error("dummy changed stack");
   dummy_hold_a: assert property (
      dummy && end_cycle && !pc_low_wr |=> pc == $past(pc))
      else $error("dummy cycle moved the counter");
   full_hold_a: assert property (
      stack_full |-> !take_irq)
      else $error("irq taken with full stack");
   call_full_a: assert property (
      end_cycle && exec_ok && op_i.call && stack_full |=>
      sp == $past(sp) + 3'h1 && stack_full)
      else $error("call blocked on full stack");
   ack_pulse_a: assert property (
      take_irq |=> irq_ack_o && pc == `PSEQ_IRQ_VECTOR ##1 !irq_ack_o)
      else $error("bad interrupt acknowledge");
   cov_call_c: cover property (push && !take_irq);
   cov_irq_c: cover property (take_irq);
   cov_over_c: cover property (push && stack_full);
   cov_skip_c: cover property (end_cycle && exec_ok && op_i.skip);
endmodule // pseq_core

// ---- core/pseq_map.svh ----
// Offsets, field positions, reset values and stack depth of the sequencer
`ifndef PSEQ_MAP_SVH
`define PSEQ_MAP_SVH
`define PSEQ_ADDR_PC_LOW 12'h000
`define PSEQ_ADDR_CTRL 12'h004
`define PSEQ_ADDR_STAT 12'h008
`define PSEQ_RESET_VECTOR 12'h000
`define PSEQ_IRQ_VECTOR 12'h004
`define PSEQ_STACK_DEPTH 8
`define PSEQ_SP_TOP 3'h0
`define PSEQ_CTRL_IRQ_EN 0
`define PSEQ_STAT_DEPTH_LSB 0
`define PSEQ_STAT_FULL 4
`define PSEQ_STAT_PEND 5
`define PSEQ_STAT_DUMMY 6
`endif

// ---- core/pseq_pkg.sv ----
// Types shared by the sequencer files
package pseq_pkg;
   // Decoded instruction class from the execute stage
   typedef struct packed {
      logic branch;       // jump or call target load
      logic call;         // push before load
      logic pop_pc;       // pop into counter
      logic skip;         // condition met on a skip
      logic [11:0] target; // branch target
   } pseq_op_t;
   // Phase state, one-hot
   typedef enum logic [3:0] {
      PH_FETCH = 4'h1,
      PH_DEC = 4'h2,
      PH_EXA = 4'h4,
      PH_EXB = 4'h8
   } pseq_phase_t;
endpackage

// ---- core/pseq_stack_mem.sv ----
// Eight-entry return address store, circular, registered read
`timescale 1ns/1ns
module pseq_stack_mem
(
   input wire logic ref_clk_i,   // system clock
   input wire logic wr_i,        // write strobe
   input wire logic [2:0] waddr_i, // write slot
   input wire logic [11:0] wdata_i, // saved counter
   input wire logic [2:0] raddr_i, // read slot
   output logic [11:0] rdata_o   // registered read data
);
   logic [11:0] mem [0:7];

   // No reset: contents are meaningless until pushed
   always_ff @(posedge ref_clk_i)
   begin
      if (wr_i)
      begin
         mem[waddr_i] <= wdata_i;
      end
      rdata_o <= mem[raddr_i];
   end
endmodule // pseq_stack_mem

// ---- dv/pseq_prog_model.sv ----
// Program memory and interrupt source model facing the sequencer
`timescale 1ns/1ns
module pseq_prog_model
(
   input wire logic ref_clk_i,      // system clock
   input wire logic rst_i,          // reset, active high
   input wire logic fetch_i,        // fetch strobe
   input wire logic [11:0] addr_i,  // fetch address
   input wire logic irq_req_i,      // bench wants an interrupt
   output pseq_pkg::pseq_op_t op_o, // decoded fetched word
   output logic op_valid_o,         // decode valid
   output logic irq_o               // interrupt request pin
);
   pseq_pkg::pseq_op_t mem [0:4095];
   ////////////////////////////////////////////////////////////////////////
   // Empty words decode as plain sequential ops
   initial
   begin
      for (int i = 0; i < 4096; i++)
         mem[i] = '0;
   end
   // Word taken during fetch, held while it executes in the same round
   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         op_o <= '0;
         irq_o <= 1'b0;
      end
      else
      begin
         irq_o <= irq_req_i;
         if (fetch_i)
            op_o <= mem[addr_i];
      end
   end
   assign op_valid_o = 1'b1; // Memory always answers in time
endmodule // pseq_prog_model

// ---- dv/pseq_core_bench.sv ----
// Self-checking bench for the program sequencer
`timescale 1ns/1ns
`include "pseq_map.svh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
   mismatches++; \
   $display("mismatch t=%0t got %0h exp %0h", $time, g, e); end end
module pseq_core_bench;
   logic ref_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, irq_req = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata;
   logic pready, pslverr, op_valid, irq, fetch, dummy, ack;
   logic [11:0] pc;
   pseq_pkg::pseq_op_t op;
   pseq_pkg::pseq_phase_t phase;
   logic [11:0] t [0:5];
   logic [15:0] seed = 16'h4646;
   int mismatches = 0, samples_checked = 0, acks = 0;
   ////////////////////////////////////////////////////////////////////////
   pseq_core pseq_core_inst (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .op_i(op), .op_valid_i(op_valid), .irq_i(irq),
      .fetch_addr_o(pc), .fetch_o(fetch), .dummy_o(dummy),
      .irq_ack_o(ack), .phase_o(phase));
   pseq_prog_model pseq_prog_model_inst (.ref_clk_i(ref_clk_i),
      .rst_i(rst_i), .fetch_i(fetch), .addr_i(pc), .irq_req_i(irq_req),
      .op_o(op), .op_valid_o(op_valid), .irq_o(irq));
   ////////////////////////////////////////////////////////////////////////
   // 250 MHz clock
   always #2 ref_clk_i = ~ref_clk_i;
   // Acknowledge count, non-blocking so reads never race it
   always @(posedge ref_clk_i)
      if (ack === 1'b1)
         acks <= acks + 1;
   // Next word of the pseudo-random sequence
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   // Expected full flag of the status word; the depth stays hidden
   function automatic logic stat_exp(input int d);
      return d >= 8;
   endfunction
   // Flags are branch, call, return, skip
   task automatic prog(input logic [11:0] a, input logic [3:0] f,
                       input logic [11:0] g);
      pseq_prog_model_inst.mem[a] = {f, g};
   endtask
   // One APB transfer, held until pready is sampled high
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] r,
                      output logic e);
      @(posedge ref_clk_i);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk_i);
      penable <= 1'b1;
      do @(posedge ref_clk_i); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Bounded wait for a fetch address, counting cycles and dummies
   task automatic wait_pc(input logic [11:0] a, output int n,
                          output int nd);
      n = 0;
      nd = 0;
      while (pc !== a && n < 300)
      begin
         if (dummy === 1'b1)
            nd++;
         @(posedge ref_clk_i);
         n++;
      end
      `CHK(pc, a)
   endtask
   task report_and_stop;
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // Watchdog, well beyond the expected run of a few hundred cycles
   initial
   begin
      repeat (5000) @(posedge ref_clk_i);
      mismatches++;
      report_and_stop;
   end
   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      logic [31:0] r;
      logic e;
      int n, nd;
      #1;
      // Nine nested calls overflow the stack; returns unwind it
      for (int i = 0; i < 9; i++)
         prog(12'(i * 16), 4'hC, 12'((i + 1) * 16));
      for (int i = 2; i < 9; i++)
         prog(12'(i * 16 + 1), 4'h2, 12'h000);
      prog(12'h098, 4'h2, 12'h000);
      prog(`PSEQ_IRQ_VECTOR, 4'h2, 12'h000);
      // Taken skip must drop the branch to 12'h300
      prog(12'h0A5, 4'h1, 12'h000);
      prog(12'h0A6, 4'h8, 12'h300);
      for (int i = 0; i < 6; i++)
      begin
         seed = lfsr(seed);
         t[i] = {1'b1, 3'(i), seed[7:0]};
      end
      prog(12'h0A7, 4'h8, t[0]);
      for (int i = 0; i < 5; i++)
         prog(t[i], 4'h8, t[i + 1]);
      repeat (3) @(posedge ref_clk_i);
      `CHK(pc, `PSEQ_RESET_VECTOR)
      rst_i <= 1'b0;
      for (int k = 0; k < 8; k++)
      begin
         @(posedge ref_clk_i);
         `CHK(phase, 4'h1 << (k % 4))
         `CHK(fetch, k % 4 == 0)
      end
      $display("test phases done");
      wait_pc(12'h090, n, nd);
      apb(1'b0, `PSEQ_ADDR_STAT, 32'h0, r, e);
      `CHK(r[`PSEQ_STAT_FULL], stat_exp(8))
      apb(1'b1, `PSEQ_ADDR_CTRL, 32'h1, r, e);
      irq_req <= 1'b1;
      repeat (8) @(posedge ref_clk_i);
      apb(1'b0, `PSEQ_ADDR_STAT, 32'h0, r, e);
      `CHK(r[5], 1'b1)
      `CHK(acks, 0)
      n = 0;
      while (ack !== 1'b1 && n < 200)
      begin
         @(posedge ref_clk_i);
         n++;
      end
      irq_req <= 1'b0;
      `CHK(pc, `PSEQ_IRQ_VECTOR)
      apb(1'b1, `PSEQ_ADDR_CTRL, 32'h0, r, e);
      wait_pc(12'h011, n, nd);
      apb(1'b0, `PSEQ_ADDR_STAT, 32'h0, r, e);
      `CHK(r[`PSEQ_STAT_FULL], stat_exp(0))
      `CHK(acks, 1)
      $display("test stack done");
      apb(1'b0, 12'h00C, 32'h0, r, e);
      `CHK(e, 1'b1)
      apb(1'b1, `PSEQ_ADDR_PC_LOW, 32'h000000A5, r, e);
      wait_pc(12'h0A5, n, nd);
      `CHK(n < 3, 1'b1)
      wait_pc(t[0], n, nd);
      for (int i = 1; i < 6; i++)
      begin
         wait_pc(t[i], n, nd);
         `CHK(n, 8)
         `CHK(nd, 4)
      end
      apb(1'b1, `PSEQ_ADDR_PC_LOW, 32'h0000005A, r, e);
      wait_pc({t[5][11:8], 8'h5A}, n, nd);
      `CHK(n < 3, 1'b1)
      $display("test branches done");
      report_and_stop;
   end
endmodule // pseq_core_bench
